// ---- rtl/sfs_pkg.sv ----
// Constants and types for the serial flash status and read command block.
// Assumes a 250 MHz system clock and an SPI host driving the link pins.
package sfs_pkg;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
    localparam logic [7:0] OP_RD_STAT1 = 8'h05;
    localparam logic [7:0] OP_RD_STAT2 = 8'h35;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_DUAL_IO = 8'hbb;
    // Status field layout
    localparam logic [7:0] SR1_WR_MASK = 8'hfc;
    localparam logic [7:0] SR2_WR_MASK = 8'h7b;
    localparam logic [7:0] LOCK_MASK = 8'h38;
    localparam logic [7:0] MODE1_MASK = 8'h01;
    localparam logic [7:0] SHORT_CLR_MASK = 8'h42;
    localparam int B_QUAD = 1;
    localparam int B_CMPL = 6;
    localparam logic [7:0] SR_RST = 8'h00;
    // Bit counts
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] DUAL_IO_BITS = 6'h20;
    localparam logic [5:0] DUMMY_CLKS = 6'h08;
    localparam logic [5:0] WSR_SHORT = 6'h08;
    localparam logic [5:0] WSR_LONG = 6'h10;
    localparam logic [5:0] CNT_SAT = 6'h3f;
    localparam logic [1:0] CONT_MODE = 2'h2;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LANE1 = 4'h1;
    localparam logic [3:0] LANE2 = 4'h2;
    localparam logic [3:0] LANE4 = 4'h4;
    localparam logic [3:0] OE1 = 4'h2;
    localparam logic [3:0] OE2 = 4'h3;
    localparam logic [3:0] OE4 = 4'hf;
    localparam logic [5:0] PIN_RST = 6'h20;
    // Array and timing
    localparam int MEM_AW = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int STATUS_WRITE_CYCLE_TIME_NS = 10000000;
    localparam int STATUS_WRITE_CYCLES_DEF =
        (STATUS_WRITE_CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WCYC_W = 22;
    typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_STAT, ST_WSTAT, ST_SKIP} sfs_state_t;
endpackage : sfs_pkg

// ---- rtl/sfs_byte_if.sv ----
// Byte stream carrier with valid and ready.
// Assumes both ends share one clock.
interface sfs_byte_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfs_byte_if

// ---- rtl/sfs_mem.sv ----
// Byte array behind the read path, registered read port.
// Assumes loads and reads share the system clock.
module sfs_mem #(
    parameter int AW = 8,
    parameter int DW = 8
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic load_en,
    input wire logic [AW-1:0] load_addr,
    input wire logic [DW-1:0] load_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data_reg,
    output logic rd_valid_reg
);
    logic [DW-1:0] cell_mem [2**AW];
    // Fill port and registered read
    always_ff @(posedge clock)
    begin
        if (load_en)
            cell_mem[load_addr] <= load_data;
        if (rd_en)
            rd_data_reg <= cell_mem[rd_addr];
    end
    // Read strobe one cycle behind the request
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rd_valid_reg <= 1'b0;
        else
            rd_valid_reg <= rd_en;
    end
endmodule : sfs_mem

// ---- rtl/sfs_fifo.sv ----
// Read-data FIFO between the array fetch and the output shifter.
// Assumes flush and both sides on the system clock.
module sfs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic flush,
    sfs_byte_if.snk wr,
    sfs_byte_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slot_mem [DEPTH];
    logic [AW:0] wptr_reg;
    logic [AW:0] rptr_reg;
    // Extra pointer bit tells full from empty
    wire logic full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire logic empty = wptr_reg == rptr_reg;
    wire logic push = wr.valid && !full;
    wire logic pop = rd.ready && !empty;
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = slot_mem[rptr_reg[AW-1:0]];
    // Pointers; flush beats a same-cycle push
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end
        else if (flush)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end
        else
        begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(pop);
        end
    end
    // Storage
    always_ff @(posedge clock)
    begin
        if (push)
            slot_mem[wptr_reg[AW-1:0]] <= wr.data;
    end
endmodule : sfs_fifo

// ---- rtl/sfs_core.sv ----
// Serial flash command engine: status access, latch handling and reads.
// Assumes link pins asynchronous to clock; link clock well below clock/4.
module sfs_core #(
    parameter int unsigned STATUS_WRITE_CYCLES = sfs_pkg::STATUS_WRITE_CYCLES_DEF
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic ext_busy,
    input wire logic ext_done,
    input wire logic load_en,
    input wire logic [sfs_pkg::MEM_AW-1:0] load_addr,
    input wire logic [7:0] load_data,
    output logic [7:0] status1,
    output logic [7:0] status2
);
    import sfs_pkg::*;

    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic sck_prev_reg;
    logic sel_prev_reg;
    sfs_state_t state_reg;
    sfs_state_t state_next;
    sfs_state_t op_state;
    logic [5:0] cnt_reg;
    logic [31:0] sh_reg;
    logic [3:0] lanes_reg;
    logic dummy_reg;
    logic dual_io_reg;
    logic stat_sel_reg;
    logic cont_reg;
    logic [7:2] sr1_reg;
    logic [7:0] sr2_reg;
    logic write_enable_latch;
    logic vol_en_reg;
    logic wcyc_busy_reg;
    logic [WCYC_W-1:0] wcyc_cnt_reg;
    logic [7:0] pend1_reg;
    logic [7:0] pend2_reg;
    logic [7:0] out_sr_reg;
    logic [3:0] left_reg;
    logic [3:0] io_out_reg;
    logic [3:0] io_oe_reg;
    logic [7:0] status1_reg;
    logic [7:0] status2_reg;
    logic [MEM_AW-1:0] rd_addr_reg;
    logic fetch_on_reg;
    logic rd_pend_reg;
    logic [7:0] mem_data;
    logic mem_valid;

    sfs_byte_if #(.W(8)) fill_if ();
    sfs_byte_if #(.W(8)) drain_if ();

    // Two-flop synchronisers on every link pin
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta_reg <= PIN_RST;
            pin_sync_reg <= PIN_RST;
            sck_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= {cs_n, sck, io_in};
            pin_sync_reg <= pin_meta_reg;
            sck_prev_reg <= pin_sync_reg[4];
            sel_prev_reg <= !pin_sync_reg[5];
        end
    end

    // Link edges and frame boundaries
    wire logic cs_low = !pin_sync_reg[5];
    wire logic [3:0] io_s = pin_sync_reg[3:0];
    wire logic sck_rise = pin_sync_reg[4] && !sck_prev_reg;
    wire logic sck_fall = !pin_sync_reg[4] && sck_prev_reg;
    wire logic frame_start = cs_low && !sel_prev_reg;
    wire logic frame_end = !cs_low && sel_prev_reg;

    // Status view; busy merges own write cycle and outside program/erase
    wire logic busy = wcyc_busy_reg || ext_busy;
    wire logic [7:0] sr1_view = {sr1_reg, write_enable_latch, busy};
    wire logic quad_io_enable = sr2_reg[B_QUAD];

    // Input shifting, two lines during dual I/O address
    wire logic in_dual = (state_reg == ST_ADDR) && dual_io_reg;
    wire logic [31:0] sh_in = in_dual ? {sh_reg[29:0], io_s[1:0]} : {sh_reg[30:0], io_s[0]};
    wire logic [5:0] step = in_dual ? 6'h02 : 6'h01;
    wire logic [5:0] cnt_step = (cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + step;
    wire logic [7:0] op_byte = sh_in[7:0];
    wire logic opc_done = (state_reg == ST_OPC) && (cnt_step == OPC_BITS);
    wire logic [5:0] addr_bits = dual_io_reg ? DUAL_IO_BITS : ADDR_BITS;
    wire logic addr_done = (state_reg == ST_ADDR) && (cnt_step == addr_bits);
    wire logic dummy_done = (state_reg == ST_DUMMY) && (cnt_step == DUMMY_CLKS);
    wire logic [23:0] addr_full = dual_io_reg ? sh_in[31:8] : sh_in[23:0];

    // Opcode decode
    wire logic op_is_stat = (op_byte == OP_RD_STAT1) || (op_byte == OP_RD_STAT2);
    wire logic op_is_quad = op_byte == OP_QUAD_OUT;
    wire logic op_is_dual = (op_byte == OP_DUAL_OUT) || (op_byte == OP_DUAL_IO);
    wire logic op_dummy = (op_byte == OP_FAST) || (op_byte == OP_DUAL_OUT) || op_is_quad;
    wire logic op_is_read = (op_byte == OP_READ) || op_dummy || (op_byte == OP_DUAL_IO);
    wire logic read_ok = op_is_read && (!op_is_quad || quad_io_enable);
    wire logic wstat_ok = (op_byte == OP_WR_STAT) && (write_enable_latch || vol_en_reg);
    wire logic [3:0] op_lanes = op_is_quad ? LANE4 : (op_is_dual ? LANE2 : LANE1);
    wire logic op_fire = sck_rise && opc_done && !busy;
    assign op_state = op_is_stat ? ST_STAT : (busy ? ST_SKIP : (read_ok ? ST_ADDR :
        (wstat_ok ? ST_WSTAT : ST_SKIP)));

    // Frame sequencer
    always_comb
    begin
        state_next = state_reg;
        if (!cs_low)
            state_next = ST_IDLE;
        else if (frame_start)
            state_next = cont_reg ? (busy ? ST_SKIP : ST_ADDR) : ST_OPC;
        else if (sck_rise)
        begin
            case (state_reg)
                ST_OPC: if (opc_done) state_next = op_state;
                ST_ADDR: if (addr_done) state_next = dummy_reg ? ST_DUMMY : ST_DATA;
                ST_DUMMY: if (dummy_done) state_next = ST_DATA;
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (frame_start || !cs_low || (sck_rise && state_next != state_reg))
                cnt_reg <= '0;
            else if (sck_rise)
                cnt_reg <= cnt_step;
            if (sck_rise)
                sh_reg <= sh_in;
        end
    end

    // Per-instruction settings; continued dual I/O frames reuse the dual layout
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lanes_reg <= LANE1;
            dummy_reg <= 1'b0;
            dual_io_reg <= 1'b0;
            stat_sel_reg <= 1'b0;
            cont_reg <= 1'b0;
        end
        else if (frame_start && cont_reg)
        begin
            lanes_reg <= LANE2;
            dummy_reg <= 1'b0;
            dual_io_reg <= 1'b1;
        end
        else if (sck_rise && opc_done)
        begin
            lanes_reg <= op_lanes;
            dummy_reg <= op_dummy;
            dual_io_reg <= op_byte == OP_DUAL_IO;
            stat_sel_reg <= op_byte == OP_RD_STAT2;
        end
        else if (sck_rise && addr_done && dual_io_reg)
            cont_reg <= sh_in[5:4] == CONT_MODE;
    end

    // Status write outcome
    wire logic wr_long = cnt_reg == WSR_LONG;
    wire logic wr_ok = frame_end && (state_reg == ST_WSTAT) && (wr_long || cnt_reg == WSR_SHORT);
    wire logic [7:0] wr_b1 = wr_long ? sh_reg[15:8] : sh_reg[7:0];
    wire logic [7:2] sr1_new = (sr1_reg & ~SR1_WR_MASK[7:2]) | (wr_b1[7:2] & SR1_WR_MASK[7:2]);
    wire logic [7:0] sr2_long = (sr2_reg & ~SR2_WR_MASK) | (sh_reg[7:0] & SR2_WR_MASK);
    wire logic [7:0] sr2_short = sr2_reg & ~SHORT_CLR_MASK;
    wire logic [7:0] keep_set = vol_en_reg ? (LOCK_MASK | MODE1_MASK) : LOCK_MASK;
    wire logic [7:0] sr2_new = (wr_long ? sr2_long : sr2_short) | (sr2_reg & keep_set);
    wire logic cycle_end = wcyc_busy_reg && (wcyc_cnt_reg == '0);
    wire logic wel_set = op_fire && (op_byte == OP_WR_ENABLE);
    wire logic wel_clr = cycle_end || ext_done || (op_fire && op_byte == OP_WR_DISABLE);
    wire logic vol_set = op_fire && (op_byte == OP_VOL_ENABLE);
    wire logic vol_clr = wr_ok || (op_fire && op_byte == OP_WR_DISABLE);

    // Latch flags; a same-cycle set wins over a clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            write_enable_latch <= 1'b0;
            vol_en_reg <= 1'b0;
        end
        else
        begin
            write_enable_latch <= wel_set || (write_enable_latch && !wel_clr);
            vol_en_reg <= vol_set || (vol_en_reg && !vol_clr);
        end
    end

    // Status bits and the self-timed non-volatile write cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sr1_reg <= SR_RST[7:2];
            sr2_reg <= SR_RST;
            pend1_reg <= SR_RST;
            pend2_reg <= SR_RST;
            wcyc_busy_reg <= 1'b0;
            wcyc_cnt_reg <= '0;
        end
        else if (cycle_end)
        begin
            sr1_reg <= pend1_reg[7:2];
            sr2_reg <= pend2_reg;
            wcyc_busy_reg <= 1'b0;
        end
        else if (wcyc_busy_reg)
            wcyc_cnt_reg <= wcyc_cnt_reg - 1'b1;
        else if (wr_ok && vol_en_reg)
        begin
            sr1_reg <= sr1_new;
            sr2_reg <= sr2_new;
        end
        else if (wr_ok)
        begin
            pend1_reg <= {sr1_new, 2'b00};
            pend2_reg <= sr2_new;
            wcyc_busy_reg <= 1'b1;
            wcyc_cnt_reg <= WCYC_W'(STATUS_WRITE_CYCLES - 1);
        end
    end

    // Array prefetch into the FIFO; a full FIFO stalls the fetch
    wire logic start_fetch = sck_rise && addr_done;
    wire logic fetch_go = fetch_on_reg && !rd_pend_reg && fill_if.ready && !start_fetch;
    assign fill_if.valid = mem_valid;
    assign fill_if.data = mem_data;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fetch_on_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= '0;
        end
        else
        begin
            fetch_on_reg <= start_fetch || (fetch_on_reg && cs_low);
            rd_pend_reg <= fetch_go || (rd_pend_reg && !mem_valid);
            if (start_fetch)
                rd_addr_reg <= addr_full[MEM_AW-1:0];
            else if (fetch_go)
                rd_addr_reg <= rd_addr_reg + 1'b1;
        end
    end

    sfs_mem #(.AW(MEM_AW), .DW(8)) u_mem (
        .clock(clock),
        .arst_n(arst_n),
        .load_en(load_en),
        .load_addr(load_addr),
        .load_data(load_data),
        .rd_en(fetch_go),
        .rd_addr(rd_addr_reg),
        .rd_data_reg(mem_data),
        .rd_valid_reg(mem_valid)
    );

    sfs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .flush(start_fetch),
        .wr(fill_if.snk),
        .rd(drain_if.src)
    );

    // Output shifter; top bits leave first so dual pairs go odd on line 1
    wire logic out_phase = (state_reg == ST_STAT) || (state_reg == ST_DATA);
    wire logic need_byte = left_reg == '0;
    wire logic [7:0] stat_byte = stat_sel_reg ? sr2_reg : sr1_view;
    wire logic stat_msb = stat_byte[7];
    wire logic [7:0] src_byte = need_byte ? ((state_reg == ST_STAT) ? stat_byte : drain_if.data) : out_sr_reg;
    wire logic [3:0] lane_bits = (lanes_reg == LANE4) ? src_byte[7:4] :
        ((lanes_reg == LANE2) ? {2'b00, src_byte[7:6]} : {2'b00, src_byte[7], 1'b0});
    wire logic [3:0] lane_oe = (lanes_reg == LANE4) ? OE4 : ((lanes_reg == LANE2) ? OE2 : OE1);
    wire logic shift_out = out_phase && sck_fall;
    assign drain_if.ready = shift_out && need_byte && (state_reg == ST_DATA);
    // Lines released at deselect and held off through dummy clocks
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_sr_reg <= '0;
            left_reg <= '0;
            io_out_reg <= '0;
            io_oe_reg <= '0;
        end
        else if (!cs_low || frame_start)
        begin
            left_reg <= '0;
            io_oe_reg <= '0;
        end
        else if (shift_out)
        begin
            io_out_reg <= lane_bits;
            io_oe_reg <= lane_oe;
            out_sr_reg <= src_byte << lanes_reg;
            left_reg <= (need_byte ? BYTE_BITS : left_reg) - lanes_reg;
        end
    end

    // Registered status outputs
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status1_reg <= SR_RST;
            status2_reg <= SR_RST;
        end
        else
        begin
            status1_reg <= sr1_view;
            status2_reg <= sr2_reg;
        end
    end

    assign io_out = io_out_reg;
    assign io_oe = io_oe_reg;
    assign status1 = status1_reg;
    assign status2 = status2_reg;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_stat_first;
        (state_reg == ST_STAT) && sck_fall && need_byte;
    endsequence
    sequence s_bad_count;
        frame_end && (state_reg == ST_WSTAT) && !wr_ok;
    endsequence
    a_wrdis_clears_latch:
        assert property (op_fire && op_byte == OP_WR_DISABLE |=> !write_enable_latch && !vol_en_reg)
        else $error("write disable left a latch set");
    a_cycle_end_clears:
        assert property (cycle_end |=> !write_enable_latch && !wcyc_busy_reg && sr2_reg == $past(pend2_reg))
        else $error("write cycle end did not clear busy and latch");
    a_volatile_no_busy:
        assert property (wr_ok && vol_en_reg && !wcyc_busy_reg |=> !wcyc_busy_reg && sr2_reg == $past(sr2_new))
        else $error("volatile write wrong");
    a_wstat_needs_enable:
        assert property (state_reg == ST_OPC && state_next == ST_WSTAT |-> write_enable_latch || vol_en_reg)
        else $error("status write accepted without enable");
    a_lock_bits_sticky:
        assert property (##1 ((($past(sr2_reg) & ~sr2_reg) & LOCK_MASK) == 8'h00))
        else $error("lock bit cleared");
    a_bad_count_ignored:
        assert property (s_bad_count |=> $stable(sr2_reg) && $stable(sr1_reg) && !wcyc_busy_reg)
        else $error("status write with wrong bit count executed");
    a_busy_read_skipped:
        assert property (sck_rise && opc_done && busy && op_is_read |=> state_reg == ST_SKIP)
        else $error("read accepted while busy");
    a_quad_needs_enable:
        assert property (state_reg == ST_OPC && state_next == ST_ADDR && op_is_quad |-> quad_io_enable)
        else $error("quad read without quad enable");
    a_stat_msb_first:
        assert property (s_stat_first |=> io_out_reg[1] == $past(stat_msb) && io_oe_reg == OE1)
        else $error("status bit order wrong");
    a_deselect_ends:
        assert property (frame_end |=> state_reg == ST_IDLE && io_oe_reg == 4'h0)
        else $error("deselect did not end instruction");
endmodule : sfs_core

// ---- bench/sfs_host.sv ----
// SPI host model for the link pins, mode 0, one frame at a time.
// Assumes the bench calls start, shift or get, then stop.
module sfs_host(
    output logic cs_n,
    output logic sck,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {cs_n, sck, io_in} = 6'h20;
    // Msb first, changed while sck is low, taken on the rise
    task shift(input logic [31:0] d, input int n, input int w);
        logic [31:0] s;
        s = d << (32 - n * w);
        repeat (n)
        begin
            io_in = (w == 1) ? {~io_in[3:1], s[31]} : {~io_in[3:2], s[31:30]};
            s = s << w;
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
    endtask : shift
    // Released lines toggle so a stale level never reads as data
    task get(input int n, input int w, output logic [31:0] r);
        r = 32'h0;
        repeat (n)
        begin
            io_in = ~io_in;
            #62.5 r = (r << w) | 32'((w == 1) ? {3'h0, io_out[1]} : (w == 2) ? {2'h0, io_out[1:0]} : io_out);
            sck = 1'b1;
            #62.5 sck = 1'b0;
        end
    endtask : get
    task start;
        #100 cs_n = 1'b0;
    endtask : start
    // Deselect right after the last fall ends the instruction
    task stop;
        #100 cs_n = 1'b1;
        #200;
    endtask : stop
endmodule : sfs_host

// ---- bench/sfs_core_tb.sv ----
// Self-checking bench for the serial flash command engine.
// Assumes the host model on the link and an array filled before reads.
module sfs_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sfs_pkg::*;
    typedef struct {logic [7:0] op; logic [7:0] a; int aw; int dum; int ow; logic [15:0] e;} sfs_row_t;
    // Two bytes per row, so the address step shows too
    sfs_row_t rows [4] = '{'{8'h03, 8'h40, 1, 0, 1, 16'h1a1b}, '{8'h0b, 8'h41, 1, 8, 1, 16'h1b18},
        '{8'h3b, 8'h7f, 1, 8, 2, 16'h25da}, '{8'hbb, 8'h00, 2, 0, 2, 16'h5a5b}};
    logic clock = 1'b0, arst_n = 1'b0, load_en = 1'b0, ext_done = 1'b0, ext_busy = 1'b0;
    logic [7:0] load_addr = 8'h00, load_data = 8'h00, status1, status2;
    logic cs_n, sck;
    logic [3:0] io_in, io_out, io_oe, oe_seen;
    logic [31:0] r;
    int i, bad_count, checked;
    sfs_core #(.STATUS_WRITE_CYCLES(2000)) dut_u (.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ext_busy(ext_busy), .ext_done(ext_done), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .status1(status1), .status2(status2));
    sfs_host host_u (.cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out));
    initial forever #2 clock = ~clock;
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // Frames end on a falling clock so status is sampled settled
    task frame(input logic [7:0] op, input logic [15:0] d, input int n);
        host_u.start();
        host_u.shift(32'(op), 8, 1);
        host_u.shift(32'(d), n, 1);
        host_u.stop();
        @(negedge clock);
    endtask : frame
    task rd(input logic [7:0] op, input logic [7:0] a, input int aw, input int dum, input int ow);
        host_u.start();
        host_u.shift(32'(op), 8, 1);
        if (aw == 2)
            host_u.shift({16'h0, a, 8'h00}, 16, 2);
        else
            host_u.shift({24'h0, a}, 24, 1);
        host_u.shift(32'h0, dum, 1);
        host_u.get(16 / ow, ow, r);
        // Enables of the last data bit still stand before deselect
        oe_seen = io_oe;
        host_u.stop();
    endtask : rd
    initial
    begin
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        chk("status reset", 32'h0, {status1, status2});
        // Fill the array with a pattern the reads can predict
        for (i = 0; i < 256; i++)
        begin
            load_addr = i[7:0];
            load_data = i[7:0] ^ 8'h5a;
            load_en = 1'b1;
            @(negedge clock);
        end
        load_en = 1'b0;
        foreach (rows[k])
        begin
            rd(rows[k].op, rows[k].a, rows[k].aw, rows[k].dum, rows[k].ow);
            chk("read data", 32'(rows[k].e), r);
            chk("read lanes", (rows[k].ow == 2) ? 32'h3 : 32'h2, 32'(oe_seen));
        end
        chk("lines released", 32'h0, 32'(io_oe));
        // Mode bits 10 let the following frame start straight at the address
        host_u.start();
        host_u.shift(32'(OP_DUAL_IO), 8, 1);
        host_u.shift({16'h0, 8'h10, 8'h20}, 16, 2);
        host_u.get(8, 2, r);
        host_u.stop();
        chk("dual io mode", 32'h4a4b, r);
        host_u.start();
        host_u.shift({16'h0, 8'h20, 8'h00}, 16, 2);
        host_u.get(8, 2, r);
        host_u.stop();
        chk("dual io again", 32'h7a7b, r);
        // Outside program running: reads ignored, status still answers
        @(negedge clock) ext_busy = 1'b1;
        rd(OP_READ, 8'h40, 1, 0, 1);
        chk("busy read oe", 32'h0, 32'(oe_seen));
        chk("outside busy", 32'h01, 32'(status1));
        @(negedge clock) ext_busy = 1'b0;
        $display("read table done");
        // Latch set, then cleared by disable and by outside completion
        frame(OP_WR_ENABLE, 16'h0, 0);
        chk("latch set", 32'h02, 32'(status1));
        frame(OP_WR_DISABLE, 16'h0, 0);
        chk("latch clear", 32'h00, 32'(status1));
        frame(OP_WR_ENABLE, 16'h0, 0);
        ext_done = 1'b1;
        @(negedge clock) ext_done = 1'b0;
        repeat (3) @(negedge clock);
        chk("latch done", 32'h00, 32'(status1));
        // Writes refused: no latch, then a cancelled volatile enable
        frame(OP_WR_STAT, 16'hfc83, 16);
        frame(OP_VOL_ENABLE, 16'h0, 0);
        frame(OP_WR_DISABLE, 16'h0, 0);
        frame(OP_WR_STAT, 16'hfc83, 16);
        chk("refused", 32'h0, {status1, status2});
        frame(OP_VOL_ENABLE, 16'h0, 0);
        frame(OP_WR_STAT, 16'h1f86, 16);
        chk("volatile", 32'h1c02, {status1, status2});
        rd(OP_RD_STAT2, 8'h00, 0, -24, 1);
        chk("status2 link", 32'h0202, r);
        rd(OP_QUAD_OUT, 8'h40, 1, 8, 4);
        chk("quad data", 32'h1a1b, r);
        chk("quad lanes", 32'hf, 32'(oe_seen));
        $display("status writes done");
        // Short non-volatile write; status read while busy
        frame(OP_WR_ENABLE, 16'h0, 0);
        frame(OP_WR_STAT, 16'h0004, 8);
        rd(OP_RD_STAT1, 8'h00, 0, -24, 1);
        chk("busy read", 32'h1f1f, r);
        for (i = 0; i < 3000 && status1[0] !== 1'b0; i++)
            @(negedge clock);
        if (i == 3000)
        begin
            bad_count++;
            finish_test();
        end
        chk("after busy", 32'h0400, {status1, status2});
        frame(OP_WR_ENABLE, 16'h0, 0);
        frame(OP_WR_STAT, 16'h0ff0, 12);
        chk("odd count", 32'h0600, {status1, status2});
        $display("busy cycle done");
        finish_test();
    end
endmodule : sfs_core_tb
